/* File: rtl/cesm_defines.svh */
// Register indices, field positions and fixed counts of the signalling block.
`ifndef CESM_DEFINES_SVH
`define CESM_DEFINES_SVH
`define CESM_WORD_W      32
`define CESM_RAM_AW      12
`define CESM_MON_LEN     35
`define CESM_MON_WORDS   4
`define CESM_MON_LAST_W  2'h3
`define CESM_IDX_CTRL    14'h2106
`define CESM_IDX_MADR_HI 12'h000
`define CESM_IDX_STAT    14'h0004
`define CESM_IDX_MASK    14'h0005
`define CESM_IDX_ROUTE   14'h0006
`define CESM_IDX_STATE   14'h0007
`define CESM_EQU_HI      7
`define CESM_EQU_LO      5
`define CESM_MON_EN_BIT  1
`define CESM_EQU_RST     3'h0
`define CESM_ROUTE_X     0
`define CESM_ROUTE_Y     1
`define CESM_EV_N        7
`define CESM_EV_ACT      0
`define CESM_EV_XFR      1
`define CESM_EV_PX       2
`define CESM_EV_PY       3
`define CESM_EV_PW       4
`define CESM_EV_PV       5
`define CESM_EV_OVR      6
`define CESM_ST_ACT      0
`define CESM_ST_XFR      1
`define CESM_ST_MON      2
`endif

/* File: rtl/cesm_pkg.sv */
// Types shared by the signalling block.
`default_nettype none
`include "cesm_defines.svh"
package cesm_pkg;
  typedef enum logic [1:0] {
    CESM_MON_IDLE  = 2'b00,
    CESM_MON_WAIT  = 2'b01,
    CESM_MON_SHIFT = 2'b10
  } cesm_mon_e_t;

  typedef struct packed {
    logic                                               ack;
    logic [31:0]                                        rdat;
    logic [2:0]                                         equ;
    logic                                               mon_en;
    logic [`CESM_MON_WORDS-1:0][`CESM_RAM_AW-1:0]       madr;
    logic [`CESM_EV_N-1:0]                              stat;
    logic [`CESM_EV_N-1:0]                              mask;
    logic [1:0]                                         route;
    logic                                               act;
    logic                                               xfr;
    logic [3:0]                                         pls;
    logic                                               ck_prev;
    logic [1:0]                                         sidx;
    logic                                               sbusy;
    logic                                               rvalid;
    logic [1:0]                                         ridx;
    logic [`CESM_RAM_AW-1:0]                            raddr;
    logic                                               rd;
    logic [`CESM_MON_WORDS-1:0][`CESM_WORD_W-1:0]       cap;
    logic [`CESM_MON_WORDS-1:0][`CESM_WORD_W-1:0]       snap;
    cesm_mon_e_t                                        mst;
    logic [1:0]                                         widx;
    logic                                               mdat;
    logic                                               mclk;
    logic                                               dx;
    logic                                               dy;
    logic                                               irq;
  } cesm_top_st_t;
endpackage : cesm_pkg
`default_nettype wire

/* File: rtl/cesm_sync.sv */
// Two flip-flop synchroniser for levels arriving from outside the clock.
`timescale 1ns/1ps
`default_nettype none
module cesm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } cesm_sync_st_t;

  cesm_sync_st_t st_q;
  cesm_sync_st_t st_d;

  // Only the second stage is visible; the first may be metastable.
  always_comb begin
    st_d.ff1 = d;
    st_d.ff2 = st_q.ff1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.ff2;
endmodule : cesm_sync
`default_nettype wire

/* File: rtl/cesm_shifter.sv */
// Serialiser for one monitor word: flag bit, data MSB first, then fill.
`timescale 1ns/1ps
`default_nettype none
`include "cesm_defines.svh"
module cesm_shifter #(
  parameter int W   = `CESM_WORD_W,
  parameter int LEN = `CESM_MON_LEN
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic         adv,
  input  wire logic         clr,
  input  wire logic [W-1:0] word,
  output logic              bit_o,
  output logic              last_o
);
  typedef struct packed {
    logic [W-1:0] sh;
    logic [5:0]   cnt;
    logic         bit_v;
    logic         busy;
  } cesm_sh_st_t;

  cesm_sh_st_t st_q;
  cesm_sh_st_t st_d;
  logic [5:0]  nxt;

  always_comb begin
    st_d = st_q;
    nxt  = st_q.cnt + 6'h1;
    if (clr) begin
      st_d = '0;
    end else if (load) begin
      st_d.sh    = word;
      st_d.cnt   = 6'h0;
      st_d.bit_v = 1'b1;
      st_d.busy  = 1'b1;
    end else if (adv && st_q.busy) begin
      if (last_o) begin
        st_d.busy  = 1'b0;
        st_d.bit_v = 1'b0;
      end else begin
        st_d.cnt = nxt;
        if (nxt <= 6'(W)) begin
          st_d.bit_v = st_q.sh[W-1];
          st_d.sh    = {st_q.sh[W-2:0], 1'b0};
        end else begin
          st_d.bit_v = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign bit_o  = st_q.bit_v;
  assign last_o = st_q.busy && (st_q.cnt == 6'(LEN - 1));
endmodule : cesm_shifter
`default_nettype wire

/* File: rtl/cesm_top.sv */
// Compute engine signalling to the host and live monitor serial export.
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cesm_defines.svh"
module cesm_top (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [15:0]             wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    pass_start,
  input  wire logic                    halt_exec,
  input  wire logic                    xfer_start,
  input  wire logic                    sample_strobe,
  input  wire logic                    pulse_x_in,
  input  wire logic                    pulse_y_in,
  input  wire logic                    pulse_w_in,
  input  wire logic                    pulse_v_in,
  output logic      [`CESM_RAM_AW-1:0] ram_addr,
  output logic                         ram_rd,
  input  wire logic [`CESM_WORD_W-1:0] ram_rdata,
  input  wire logic                    mon_ck_in,
  output logic                         engine_active_flag,
  output logic                         output_transfer_flag,
  output logic                         pulse_x,
  output logic                         pulse_y,
  output logic                         pulse_w,
  output logic                         pulse_v,
  output logic      [2:0]              equation_select,
  output logic                         digital_io_x_o,
  output logic                         digital_io_x_oe,
  output logic                         digital_io_y_o,
  output logic                         digital_io_y_oe,
  output logic                         monitor_data_pin,
  output logic                         monitor_clock_pin,
  output logic                         irq
);
  cesm_pkg::cesm_top_st_t st_q;
  cesm_pkg::cesm_top_st_t st_d;

  logic                    ck_s;
  logic                    fall;
  logic                    take;
  logic [13:0]             idx;
  logic [3:0]              pls_in;
  logic [3:0]              lead;
  logic [`CESM_EV_N-1:0]   ev;
  logic                    sh_load;
  logic                    sh_adv;
  logic                    sh_clr;
  logic [1:0]              sh_sel;
  logic                    sh_bit;
  logic                    sh_last;
  logic [`CESM_WORD_W-1:0] sh_word;
  logic [1:0]              nidx;

  function automatic logic [15:0] cesm_merge16(
    input logic [15:0] old,
    input logic [31:0] nw,
    input logic [3:0]  sel
  );
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = nw[7:0];
    end
    if (sel[1]) begin
      r[15:8] = nw[15:8];
    end
    return r;
  endfunction : cesm_merge16

  // The monitor clock comes from outside, so it is synchronised first.
  cesm_sync #(
    .W (1)
  ) u_ck_sync (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .d    (mon_ck_in),
    .q    (ck_s)
  );

  cesm_shifter #(
    .W   (`CESM_WORD_W),
    .LEN (`CESM_MON_LEN)
  ) u_shifter (
    .clk    (clk),
    .srst   (srst),
    .ce     (ce),
    .load   (sh_load),
    .adv    (sh_adv),
    .clr    (sh_clr),
    .word   (sh_word),
    .bit_o  (sh_bit),
    .last_o (sh_last)
  );

  assign fall    = st_q.ck_prev && !ck_s;
  assign take    = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign idx     = wb_adr_i[15:2];
  assign pls_in  = {pulse_v_in, pulse_w_in, pulse_y_in, pulse_x_in};
  assign lead    = pls_in & ~st_q.pls;
  assign sh_word = st_q.snap[sh_sel];

  always_comb begin
    st_d    = st_q;
    sh_load = 1'b0;
    sh_adv  = 1'b0;
    sh_clr  = 1'b0;
    sh_sel  = 2'h0;
    nidx    = st_q.widx + 2'h1;
    ev      = '0;

    // Engine pass flags; a halt in the same cycle as a start wins.
    st_d.act = st_q.act;
    if (pass_start) begin
      st_d.act = 1'b1;
    end
    if (xfer_start) begin
      st_d.xfr = 1'b1;
    end
    if (halt_exec) begin
      st_d.act = 1'b0;
      st_d.xfr = 1'b0;
    end
    st_d.pls = pls_in;

    ev[`CESM_EV_ACT] = st_d.act && !st_q.act;
    ev[`CESM_EV_XFR] = st_d.xfr && !st_q.xfr;
    ev[`CESM_EV_PX]  = lead[0];
    ev[`CESM_EV_PY]  = lead[1];
    ev[`CESM_EV_PW]  = lead[2];
    ev[`CESM_EV_PV]  = lead[3];
    // A new pass while the old one has not halted means the pass overran.
    ev[`CESM_EV_OVR] = pass_start && st_q.act && !halt_exec;

    // Register bus slave: answer one cycle after the request.
    st_d.ack = take;
    if (take) begin
      st_d.rdat = 32'h0;
      unique case (idx)
        `CESM_IDX_CTRL: begin
          st_d.rdat[`CESM_EQU_HI:`CESM_EQU_LO] = st_q.equ;
          st_d.rdat[`CESM_MON_EN_BIT]         = st_q.mon_en;
        end
        `CESM_IDX_STAT: begin
          st_d.rdat[`CESM_EV_N-1:0] = st_q.stat;
        end
        `CESM_IDX_MASK: begin
          st_d.rdat[`CESM_EV_N-1:0] = st_q.mask;
        end
        `CESM_IDX_ROUTE: begin
          st_d.rdat[1:0] = st_q.route;
        end
        `CESM_IDX_STATE: begin
          st_d.rdat[`CESM_ST_ACT] = st_q.act;
          st_d.rdat[`CESM_ST_XFR] = st_q.xfr;
          st_d.rdat[`CESM_ST_MON] =
            (st_q.mst != cesm_pkg::CESM_MON_IDLE);
        end
        default: begin
          if (idx[13:2] == `CESM_IDX_MADR_HI) begin
            st_d.rdat[`CESM_RAM_AW-1:0] = st_q.madr[idx[1:0]];
          end
        end
      endcase
      if (wb_we_i) begin
        unique case (idx)
          `CESM_IDX_CTRL: begin
            if (wb_sel_i[0]) begin
              st_d.equ    = wb_dat_i[`CESM_EQU_HI:`CESM_EQU_LO];
              st_d.mon_en = wb_dat_i[`CESM_MON_EN_BIT];
            end
          end
          `CESM_IDX_MASK: begin
            if (wb_sel_i[0]) begin
              st_d.mask = wb_dat_i[`CESM_EV_N-1:0];
            end
          end
          `CESM_IDX_ROUTE: begin
            if (wb_sel_i[0]) begin
              st_d.route = wb_dat_i[1:0];
            end
          end
          default: begin
            if (idx[13:2] == `CESM_IDX_MADR_HI) begin
              st_d.madr[idx[1:0]] = `CESM_RAM_AW'(cesm_merge16(
                16'(st_q.madr[idx[1:0]]), wb_dat_i, wb_sel_i));
            end
          end
        endcase
      end
    end

    // Read clears status, but an event in the same cycle stays set.
    if (take && !wb_we_i && (idx == `CESM_IDX_STAT)) begin
      st_d.stat = ev;
    end else begin
      st_d.stat = st_q.stat | ev;
    end
    st_d.irq = |(st_d.stat & st_d.mask);

    // Sampler: read the four monitored words on a sample strobe that comes while it is not busy.
    st_d.rvalid = st_q.rd;
    st_d.ridx   = st_q.sidx;
    st_d.rd     = 1'b0;
    if (st_q.rvalid) begin
      st_d.cap[st_q.ridx] = ram_rdata;
    end
    if (st_q.sbusy) begin
      if (st_q.sidx == `CESM_MON_LAST_W) begin
        st_d.sbusy = 1'b0;
      end else begin
        st_d.sidx  = st_q.sidx + 2'h1;
        st_d.raddr = st_q.madr[st_q.sidx + 2'h1];
        st_d.rd    = 1'b1;
      end
    end else if (sample_strobe) begin
      st_d.sbusy = 1'b1;
      st_d.sidx  = 2'h0;
      st_d.raddr = st_q.madr[0];
      st_d.rd    = 1'b1;
    end

    // Monitor sequencing runs on falling edges of the sampled clock.
    st_d.ck_prev = ck_s;
    unique case (st_q.mst)
      cesm_pkg::CESM_MON_IDLE: begin
        if (pass_start && st_q.mon_en) begin
          st_d.snap = st_q.cap;
          st_d.mst  = cesm_pkg::CESM_MON_WAIT;
        end
      end
      cesm_pkg::CESM_MON_WAIT: begin
        if (fall) begin
          sh_load   = 1'b1;
          sh_sel    = 2'h0;
          st_d.widx = 2'h0;
          st_d.mst  = cesm_pkg::CESM_MON_SHIFT;
        end
      end
      cesm_pkg::CESM_MON_SHIFT: begin
        if (fall) begin
          if (sh_last && (st_q.widx != `CESM_MON_LAST_W)) begin
            sh_load   = 1'b1;
            sh_sel    = nidx;
            st_d.widx = nidx;
          end else begin
            sh_adv = 1'b1;
            if (sh_last) begin
              st_d.mst = cesm_pkg::CESM_MON_IDLE;
            end
          end
        end
      end
      default: begin
        st_d.mst = cesm_pkg::CESM_MON_IDLE;
      end
    endcase
    // Clearing the enable abandons a word part way; the receiver must
    // discard it by the missing tail.
    if (!st_q.mon_en) begin
      sh_clr   = 1'b1;
      sh_load  = 1'b0;
      sh_adv   = 1'b0;
      st_d.mst = cesm_pkg::CESM_MON_IDLE;
    end
    st_d.mdat = st_q.mon_en &&
                (st_q.mst == cesm_pkg::CESM_MON_SHIFT) && sh_bit;
    st_d.mclk = st_q.mon_en && ck_s;

    // The new route is used so that a pin never drives without its enable.
    st_d.dx = st_d.route[`CESM_ROUTE_X] && pls_in[0];
    st_d.dy = st_d.route[`CESM_ROUTE_Y] && pls_in[1];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q     <= '0;
      st_q.equ <= `CESM_EQU_RST;
      st_q.mst <= cesm_pkg::CESM_MON_IDLE;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o             = st_q.rdat;
  assign wb_ack_o             = st_q.ack;
  assign ram_addr             = st_q.raddr;
  assign ram_rd               = st_q.rd;
  assign engine_active_flag   = st_q.act;
  assign output_transfer_flag = st_q.xfr;
  assign pulse_x              = st_q.pls[0];
  assign pulse_y              = st_q.pls[1];
  assign pulse_w              = st_q.pls[2];
  assign pulse_v              = st_q.pls[3];
  assign equation_select      = st_q.equ;
  assign digital_io_x_o       = st_q.dx;
  assign digital_io_x_oe      = st_q.route[`CESM_ROUTE_X];
  assign digital_io_y_o       = st_q.dy;
  assign digital_io_y_oe      = st_q.route[`CESM_ROUTE_Y];
  assign monitor_data_pin     = st_q.mdat;
  assign monitor_clock_pin    = st_q.mclk;
  assign irq                  = st_q.irq;
endmodule : cesm_top
`default_nettype wire

/* File: test/cesm_top_assertions.sv */
// Port-level checks of the signalling block, bound into its top module.
`timescale 1ns/1ps
`default_nettype none
module cesm_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        pass_start,
  input wire logic        halt_exec,
  input wire logic        xfer_start,
  input wire logic        pulse_x_in,
  input wire logic        engine_active_flag,
  input wire logic        output_transfer_flag,
  input wire logic [2:0]  equation_select,
  input wire logic        digital_io_x_o,
  input wire logic        digital_io_x_oe,
  input wire logic        digital_io_y_o,
  input wire logic        digital_io_y_oe,
  input wire logic        monitor_data_pin,
  input wire logic        monitor_clock_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_act_start: assert property (
    ce && pass_start && !halt_exec |=> engine_active_flag)
    else $error("active flag did not rise after pass start");
  chk_xfer_set: assert property (
    ce && xfer_start && !halt_exec |=> output_transfer_flag)
    else $error("transfer flag did not rise after transfer start");
  chk_halt_clear: assert property (
    ce && halt_exec |=> !engine_active_flag && !output_transfer_flag)
    else $error("halt left an engine flag set");
  chk_ack_once: assert property (
    ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer missing or longer than one cycle");
  chk_equ_write: assert property (
    ce && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
    && wb_adr_i == 16'h8418
    |=> ##[0:1] equation_select == $past(wb_dat_i[7:5]))
    else $error("equation select does not follow control write");
  chk_data_edge: assert property (
    $changed(monitor_data_pin) |-> !monitor_clock_pin)
    else $error("monitor data changed while its clock was high");
  chk_dio_x_out: assert property (
    ce && pulse_x_in |=> digital_io_x_o == digital_io_x_oe)
    else $error("routed pulse x did not reach its pin");
  chk_dio_y_oe: assert property (
    digital_io_y_o |-> digital_io_y_oe)
    else $error("pulse y pin driven without enable");
endmodule : cesm_chk
bind cesm_top cesm_chk i_cesm_chk (.clk(clk), .srst(srst), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .pass_start(pass_start), .halt_exec(halt_exec),
  .xfer_start(xfer_start), .pulse_x_in(pulse_x_in),
  .engine_active_flag(engine_active_flag),
  .output_transfer_flag(output_transfer_flag),
  .equation_select(equation_select), .digital_io_x_o(digital_io_x_o),
  .digital_io_x_oe(digital_io_x_oe), .digital_io_y_o(digital_io_y_o),
  .digital_io_y_oe(digital_io_y_oe), .monitor_data_pin(monitor_data_pin),
  .monitor_clock_pin(monitor_clock_pin));
`default_nettype wire

/* File: test/cesm_far.sv */
// Far side model: shared RAM, link clock source and monitor receiver.
`timescale 1ns/1ps
`default_nettype none
module cesm_far (
  input  wire logic         clk,
  input  wire logic         run,
  input  wire logic         clr,
  input  wire logic [11:0]  ram_addr,
  input  wire logic         ram_rd,
  input  wire logic         monitor_data_pin,
  input  wire logic         monitor_clock_pin,
  output logic      [31:0]  ram_rdata,
  output logic              mon_ck,
  output logic      [139:0] rx,
  output logic      [7:0]   rxn
);
  // Outside a read cycle the data toggles, so a late capture shows up.
  always @(posedge clk) begin
    ram_rdata <= ram_rd ? {4'hC, ram_addr, 4'h3, ~ram_addr} : ~ram_rdata;
  end
  // The link clock idles high between frames and is unrelated in phase.
  initial begin
    mon_ck = 1'b1;
    #3;
    forever begin
      if (run) begin
        #40 mon_ck = 1'b0;
        #40 mon_ck = 1'b1;
      end else begin
        #10;
      end
    end
  end
  always @(posedge monitor_clock_pin or posedge clr) begin
    if (clr) begin
      rx <= 140'h0;
      rxn <= 8'h0;
    end else begin
      if (rxn < 8'h8C) rx <= {rx[138:0], monitor_data_pin};
      rxn <= rxn + 8'h1;
    end
  end
endmodule : cesm_far
`default_nettype wire

/* File: test/cesm_top_bench.sv */
// Self-checking bench for the signalling block.
`timescale 1ns/1ps
`default_nettype none
module cesm_top_bench;
  logic         clk, srst, ce, cyc, stb, we, ps, hx, xs, ss, run, clr;
  logic [15:0]  adr;
  logic [3:0]   sel, pin;
  logic [31:0]  dat, rdat, wdo, rdata;
  logic [11:0]  raddr;
  logic [2:0]   eq;
  logic [139:0] rx;
  logic [7:0]   rxn;
  logic         ack, rd, mck, eaf, otf, px, py, pw, pv, irq;
  logic         dxo, dxoe, dyo, dyoe, mdp, mcp;
  int           miscompares, checks, cycles;

  cesm_top i_cesm_top (.clk(clk), .srst(srst), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack), .pass_start(ps),
    .halt_exec(hx), .xfer_start(xs), .sample_strobe(ss),
    .pulse_x_in(pin[0]), .pulse_y_in(pin[1]), .pulse_w_in(pin[2]),
    .pulse_v_in(pin[3]), .ram_addr(raddr), .ram_rd(rd), .ram_rdata(rdata),
    .mon_ck_in(mck), .engine_active_flag(eaf), .output_transfer_flag(otf),
    .pulse_x(px), .pulse_y(py), .pulse_w(pw), .pulse_v(pv),
    .equation_select(eq), .digital_io_x_o(dxo), .digital_io_x_oe(dxoe),
    .digital_io_y_o(dyo), .digital_io_y_oe(dyoe),
    .monitor_data_pin(mdp), .monitor_clock_pin(mcp), .irq(irq));
  cesm_far i_cesm_far (.clk(clk), .run(run), .clr(clr), .ram_addr(raddr),
    .ram_rd(rd), .monitor_data_pin(mdp), .monitor_clock_pin(mcp),
    .ram_rdata(rdata), .mon_ck(mck), .rx(rx), .rxn(rxn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The whole run needs under two thousand cycles; this ceiling cuts a hang.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task final_report;
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task wbx(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rdat = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wbx

  task rdchk(input logic [15:0] a, input logic [31:0] e, input string nm);
    wbx(1'b0, a, 32'h0);
    cmp(nm, e, rdat);
  endtask : rdchk

  task t_regs;
    cmp("equ_reset", 32'h0, {29'h0, eq});
    rdchk(16'h8418, 32'h0, "ctrl_reset");
    for (int e = 2; e <= 5; e++) begin
      wbx(1'b1, 16'h8418, 32'(e) << 5);
      rdchk(16'h8418, 32'(e) << 5, "ctrl");
      cmp("equ_pin", 32'(e), {29'h0, eq});
    end
    wbx(1'b1, 16'h0200, 32'hFFFFFFFF);
    rdchk(16'h0200, 32'h0, "unmapped");
    rdchk(16'h8418, 32'hA0, "ctrl_kept");
  endtask : t_regs

  task t_engine;
    wbx(1'b0, 16'h0010, 32'h0);
    ps <= 1'b1;
    tick(1);
    ps <= 1'b0;
    tick(1);
    cmp("active", 32'h1, {31'h0, eaf});
    xs <= 1'b1;
    tick(1);
    xs <= 1'b0;
    tick(1);
    cmp("transfer", 32'h1, {31'h0, otf});
    rdchk(16'h001C, 32'h3, "state");
    ps <= 1'b1;
    tick(1);
    hx <= 1'b1;
    tick(1);
    hx <= 1'b0;
    ps <= 1'b0;
    tick(1);
    cmp("flags_halt", 32'h0, {30'h0, eaf, otf});
    rdchk(16'h0010, 32'h43, "stat_engine");
    ce <= 1'b0;
    ps <= 1'b1;
    tick(1);
    ce <= 1'b1;
    ps <= 1'b0;
    tick(1);
    cmp("frozen", 32'h0, {31'h0, eaf});
  endtask : t_engine

  task t_pulses;
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m = (i % 2 == 0) ? (32'h4 << i) : 32'h0;
      wbx(1'b1, 16'h0014, m);
      pin <= 4'h1 << i;
      tick(4);
      cmp("pulse_out", 32'h1 << i, {28'h0, pv, pw, py, px});
      cmp("irq_lead", {31'h0, m != 0}, {31'h0, irq});
      rdchk(16'h0010, 32'h4 << i, "stat_lead");
      pin <= 4'h0;
      tick(4);
      rdchk(16'h0010, 32'h0, "stat_trail");
      cmp("irq_trail", 32'h0, {31'h0, irq});
    end
  endtask : t_pulses

  task t_route;
    wbx(1'b1, 16'h0018, 32'h3);
    pin <= 4'h3;
    tick(4);
    cmp("dio_oe", 32'h3, {30'h0, dyoe, dxoe});
    cmp("dio_high", 32'h3, {30'h0, dyo, dxo});
    pin <= 4'h0;
    tick(4);
    cmp("dio_low", 32'h0, {30'h0, dyo, dxo});
    wbx(1'b0, 16'h0010, 32'h0);
  endtask : t_route

  task t_monitor;
    logic [34:0] w;
    logic [7:0]  n;
    for (int i = 0; i < 4; i++) wbx(1'b1, 16'(4 * i), 32'h10 + i);
    ss <= 1'b1;
    tick(1);
    ss <= 1'b0;
    tick(8);
    wbx(1'b1, 16'h8418, 32'hA2);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    ps <= 1'b1;
    tick(1);
    ps <= 1'b0;
    run <= 1'b1;
    for (int t = 0; t < 2000 && rxn < 8'h8C; t++) tick(1);
    run <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      w = rx[139 - 35 * i -: 35];
      cmp("mon_data", {4'hC, 12'h10 + 12'(i), 4'h3, ~(12'h10 + 12'(i))},
          w[33:2]);
      cmp("mon_frame", 32'h4, {29'h0, w[34], w[1:0]});
    end
    tick(20);
    cmp("mon_idle", 32'h0, {31'h0, mdp});
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    ps <= 1'b1;
    tick(1);
    ps <= 1'b0;
    run <= 1'b1;
    tick(200);
    rdchk(16'h001C, 32'h5, "state_mon");
    wbx(1'b1, 16'h8418, 32'hA0);
    tick(2);
    cmp("abort_pins", 32'h0, {30'h0, mdp, mcp});
    n = rxn;
    tick(100);
    cmp("abort_quiet", {24'h0, n}, {24'h0, rxn});
    run <= 1'b0;
  endtask : t_monitor

  initial begin
    {srst, ce} = 2'h3;
    {cyc, stb, we, ps, hx, xs, ss, run, clr} = 9'h0;
    {adr, dat, pin, sel} = {16'h0, 32'h0, 4'h0, 4'hF};
    {miscompares, checks, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_engine();
    t_pulses();
    t_route();
    t_monitor();
    final_report();
  end
endmodule : cesm_top_bench
`default_nettype wire
